// ===== core/clkpwr_consts.svh
// Offsets, field positions, reset values and counts for the clock and power block.
// Assumes inclusion by bare name from the block and the bench.
// Function
// - Slow source changes only in fast mode
// - Fast source changes only in slow mode
// - Fast crystal claims pins, high gain
// - System source changes only with fast running
// - Divider codes give 16, 4, 2, 1
// - New divider applies within 16 cycles
// - Half rate clock on pin, enable gated
// - Seven bit trim sets fast RC rate
// - Idle bit sleeps CPU, peripherals run
// - Peripheral gate stops the peripheral clock in idle
// - Idle ends on reset or enabled interrupt
// - Power down enters halt or stop
// - Halt keeps only timer3 and watchdog clocks
// - Halt and stop wake sources
// - Low enabled pin refuses power down
// - Pins 2 to 9 wake regardless of global
// - Pins 2 to 9 also need shared enable
// - Port1 per pin wake enables
// - Pin 2 to 9 falling edges set flags whatever their enable
// - Block abnormal clock control settings
// - Reset lands in slow mode on slow RC
`ifndef CLKPWR_CONSTS_SVH
`define CLKPWR_CONSTS_SVH
// Register indices; byte address is four times the index
`define IDX_EXT_WAKE 10'h084
`define IDX_PWR_CTL 10'h087
`define IDX_P1_WAKE 10'h096
`define IDX_CLK_CTL 10'h0D8
`define IDX_RC_TRIM 10'h0F6
`define IDX_CKOUT_EN 10'h100
`define IDX_STATUS 10'h101
`define IDX_PIN_FLAGS 10'h102
// Reset values
`define RST_CLK_CTL 8'h23
`define RST_ZERO 8'h00
// Power control fields
`define PWR_DOWN_BIT 1
`define PWR_IDLE_BIT 0
`define PWR_KEEP_MASK 8'h8C
// Divider window length in cycles
`define PSC_WINDOW 16
// Crystal settling wait in cycles, 2 ms of mclk
`define XTAL_WAIT_CYC 20000
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== core/clkpwr_pkg.sv
// Types shared by the clock and power block.
// Assumes the constants header sits beside it.
package clkpwr_pkg;
    // Clock control register layout
    typedef struct packed {
        logic slow_source_pick;
        logic fast_source_pick;
        logic slow_osc_halt_on_powerdown;
        logic periph_gate_in_idle;
        logic fast_osc_halt;
        logic sysclk_fast_pick;
        logic [1:0] sysclk_divider;
    } clk_ctl_t;
    // Operating states, one-hot
    typedef enum logic [3:0] {
        PW_RUN = 4'b0001,
        PW_IDLE = 4'b0010,
        PW_HALT = 4'b0100,
        PW_STOP = 4'b1000
    } pwr_state_t;
endpackage

// ===== core/system_clock_and_power_modes.sv
// System clock selection, divider, clock output and low-power sequencing.
// Assumes an AXI4-Lite master on mclk and asynchronous pins on the wake inputs.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "clkpwr_consts.svh"
module system_clock_and_power_modes import clkpwr_pkg::*; #(
    parameter logic [6:0] TRIM_RESET = 7'h40,
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] external_irq_pin,
    input wire logic [7:0] port1_pin,
    input wire logic [1:0] ex01_wake_en,
    input wire logic shared_pin_lowvolt_irq_enable,
    input wire logic irq_pending,
    input wire logic timer3_irq,
    input wire logic timer3_wake_en,
    input wire logic timer3_en,
    input wire logic wdt_en,
    output logic sys_tick,
    output logic half_rate_clock_out,
    output logic half_rate_clock_out_oe,
    output logic fast_osc_run,
    output logic slow_osc_run,
    output logic xtal_pins_osc,
    output logic osc_high_gain,
    output logic sysclk_is_fast,
    output logic [6:0] fast_rc_trim_value,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic timer3_clk_en,
    output logic wdt_clk_en
);
    // ==========================================
    // Elaboration checks
    generate
        if (ADDR_W < 12) begin : g_bad_addr
            $error("address width too small for the register map");
        end
    endgenerate

    // ==========================================
    // State
    clk_ctl_t ctl_r, ctl_nxt; // Clock control
    logic [7:0] ext_wake_r; // Pins 2..9 wake enables
    logic [7:0] p1_wake_r; // Port1 wake enables
    logic [7:0] pwr_keep_r; // Plain storage bits
    logic down_r, idle_r; // Power down and idle bits
    logic [6:0] trim_r; // Fast RC trim
    logic ckout_en_r; // Clock pin enable
    logic [7:0] pin_flag_r; // Falling edge flags 2..9
    pwr_state_t st_r, st_nxt; // Operating state
    logic [1:0] psc_act_r; // Divider in force
    logic [3:0] win_r; // Divider window counter
    logic [3:0] div_cnt_r; // Divider counter
    logic half_r; // Half rate clock
    logic [17:0] sync1_r, sync2_r, pin_q_r; // Pin synchronisers

    // ==========================================
    // Bus slave state
    logic aw_have_r, w_have_r; // Captured halves of a write
    logic [9:0] aw_idx_r; // Write word index
    logic [7:0] w_data_r; // Write low byte
    logic w_lane_r; // Low byte lane strobed
    logic bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;

    // ==========================================
    // Pin synchronisers; the second stage is read, the third keeps the previous sample for edges
    always_ff @(posedge mclk) begin
        sync1_r <= {port1_pin, external_irq_pin};
        sync2_r <= sync1_r;
        pin_q_r <= sync2_r;
    end
    wire [9:0] int_pin = sync2_r[9:0];
    wire [7:0] p1_now = sync2_r[17:10];
    wire [7:0] p1_prev = pin_q_r[17:10];
    wire [7:0] fall_29 = pin_q_r[9:2] & ~int_pin[9:2];

    // ==========================================
    // Write decode
    wire wr_fire = aw_have_r & w_have_r & ~bvalid_r;
    wire wr_ok = wr_fire & w_lane_r;
    wire wr_ext = wr_ok && (aw_idx_r == `IDX_EXT_WAKE);
    wire wr_pwr = wr_ok && (aw_idx_r == `IDX_PWR_CTL);
    wire wr_p1 = wr_ok && (aw_idx_r == `IDX_P1_WAKE);
    wire wr_ctl = wr_ok && (aw_idx_r == `IDX_CLK_CTL);
    wire wr_trim = wr_ok && (aw_idx_r == `IDX_RC_TRIM);
    wire wr_cke = wr_ok && (aw_idx_r == `IDX_CKOUT_EN);
    wire wr_flag = wr_ok && (aw_idx_r == `IDX_PIN_FLAGS);
    wire wr_known = (aw_idx_r == `IDX_EXT_WAKE) || (aw_idx_r == `IDX_PWR_CTL)
        || (aw_idx_r == `IDX_P1_WAKE) || (aw_idx_r == `IDX_CLK_CTL)
        || (aw_idx_r == `IDX_RC_TRIM) || (aw_idx_r == `IDX_CKOUT_EN)
        || (aw_idx_r == `IDX_STATUS) || (aw_idx_r == `IDX_PIN_FLAGS);

    // ==========================================
    // Wake and refusal conditions
    // Pins 0..1 enable alone; pins 2..9 need the shared enable too to wake, but not to refuse power down
    wire low_01 = |(~int_pin[1:0] & ex01_wake_en);
    wire low_29 = |(~int_pin[9:2] & ext_wake_r);
    wire edge_29 = |(fall_29 & ext_wake_r);
    wire p1_change = |((p1_now ^ p1_prev) & p1_wake_r);
    // Global interrupt enable deliberately absent from this path
    wire pin_wake = low_01 | p1_change | ((low_29 | edge_29) & shared_pin_lowvolt_irq_enable);
    wire down_block = low_01 | low_29;
    wire halt_wake = pin_wake | (timer3_irq & timer3_wake_en);
    wire down_go = wr_pwr & w_data_r[`PWR_DOWN_BIT] & ~down_block & (st_r == PW_RUN);
    wire idle_go = wr_pwr & w_data_r[`PWR_IDLE_BIT] & ~down_go & (st_r == PW_RUN);
    wire woke = (st_r != PW_RUN) & (st_nxt == PW_RUN);

    // ==========================================
    // Clock control write filter
    // A refused bit keeps its value while its neighbours still update
    clk_ctl_t wv;
    assign wv = clk_ctl_t'(w_data_r);
    always_comb begin
        ctl_nxt = ctl_r;
        if (wr_ctl) begin
            ctl_nxt.slow_osc_halt_on_powerdown = wv.slow_osc_halt_on_powerdown;
            ctl_nxt.periph_gate_in_idle = wv.periph_gate_in_idle;
            ctl_nxt.sysclk_divider = wv.sysclk_divider;
            if (ctl_r.sysclk_fast_pick) begin
                ctl_nxt.slow_source_pick = wv.slow_source_pick;
            end
            if (!ctl_r.sysclk_fast_pick) begin
                ctl_nxt.fast_source_pick = wv.fast_source_pick;
                ctl_nxt.fast_osc_halt = wv.fast_osc_halt;
            end
            // Never both halt and fast pick; the pick loses
            if (!ctl_r.fast_osc_halt && !(ctl_nxt.fast_osc_halt && wv.sysclk_fast_pick)) begin
                ctl_nxt.sysclk_fast_pick = wv.sysclk_fast_pick;
            end
        end
    end

    // ==========================================
    // Software registers; reset lands in slow mode on the slow RC
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_r <= clk_ctl_t'(`RST_CLK_CTL);
            ext_wake_r <= `RST_ZERO;
            p1_wake_r <= `RST_ZERO;
            pwr_keep_r <= `RST_ZERO;
            trim_r <= TRIM_RESET;
            ckout_en_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            if (wr_ext) ext_wake_r <= w_data_r;
            if (wr_p1) p1_wake_r <= w_data_r;
            if (wr_pwr) pwr_keep_r <= w_data_r & `PWR_KEEP_MASK;
            if (wr_trim) trim_r <= w_data_r[6:0];
            if (wr_cke) ckout_en_r <= w_data_r[0];
        end
    end

    // ==========================================
    // Edge flags, set whatever the enable; set beats a write-one clear
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            always_ff @(posedge mclk) begin
                if (rst) begin
                    pin_flag_r[gi] <= 1'b0;
                end else if (fall_29[gi]) begin
                    pin_flag_r[gi] <= 1'b1;
                end else if (wr_flag && w_data_r[gi]) begin
                    pin_flag_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================
    // Power state sequencing
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            PW_RUN: begin
                // Stop only when the slow halt bit is set
                if (down_go) st_nxt = ctl_r.slow_osc_halt_on_powerdown ? PW_STOP : PW_HALT;
                else if (idle_go) st_nxt = PW_IDLE;
            end
            PW_IDLE: if (irq_pending) st_nxt = PW_RUN;
            PW_HALT: if (halt_wake) st_nxt = PW_RUN;
            PW_STOP: if (pin_wake) st_nxt = PW_RUN;
            default: st_nxt = PW_RUN;
        endcase
    end

    // Mode bits follow the state and drop on wake
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= PW_RUN;
            down_r <= 1'b0;
            idle_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            down_r <= down_go | (down_r & ~woke);
            idle_r <= idle_go | (idle_r & ~woke);
        end
    end

    // ==========================================
    // Divider: new code is picked up at the window end
    wire [3:0] div_term = (psc_act_r == 2'b00) ? 4'hF : (psc_act_r == 2'b01) ? 4'h3 :
        (psc_act_r == 2'b10) ? 4'h1 : 4'h0;
    wire sys_run = (st_r == PW_RUN) | (st_r == PW_IDLE);
    assign sys_tick = sys_run & (div_cnt_r >= div_term);
    always_ff @(posedge mclk) begin
        if (rst) begin
            psc_act_r <= 2'(`RST_CLK_CTL);
            win_r <= 4'h0;
            div_cnt_r <= 4'h0;
            half_r <= 1'b0;
        end else begin
            win_r <= win_r + 4'h1;
            if (win_r == 4'hF) psc_act_r <= ctl_r.sysclk_divider;
            div_cnt_r <= sys_tick ? 4'h0 : (sys_run ? div_cnt_r + 4'h1 : div_cnt_r);
            if (sys_tick) half_r <= ~half_r;
        end
    end

    // ==========================================
    // Clock and oscillator outputs
    assign half_rate_clock_out = half_r;
    assign half_rate_clock_out_oe = ckout_en_r;
    assign xtal_pins_osc = ctl_r.fast_source_pick | ctl_r.slow_source_pick;
    assign osc_high_gain = ctl_r.fast_source_pick;
    assign sysclk_is_fast = ctl_r.sysclk_fast_pick;
    assign fast_rc_trim_value = trim_r;
    // Halt and stop kill the fast oscillator; stop also the slow one
    assign fast_osc_run = ~ctl_r.fast_osc_halt & sys_run;
    assign slow_osc_run = (st_r != PW_STOP);
    assign cpu_clk_en = (st_r == PW_RUN);
    assign periph_clk_en = (st_r == PW_RUN)
        | ((st_r == PW_IDLE) & ~ctl_r.periph_gate_in_idle);
    assign timer3_clk_en = timer3_en & (st_r != PW_STOP);
    assign wdt_clk_en = wdt_en;

    // ==========================================
    // Read mux
    wire [9:0] ar_idx = s_axi_araddr[11:2];
    wire [7:0] stat_v = {2'b00, st_r, down_r, idle_r};
    wire [7:0] rd_v = (ar_idx == `IDX_EXT_WAKE) ? ext_wake_r :
        (ar_idx == `IDX_PWR_CTL) ? (pwr_keep_r | {6'h00, down_r, idle_r}) :
        (ar_idx == `IDX_P1_WAKE) ? p1_wake_r :
        (ar_idx == `IDX_CLK_CTL) ? 8'(ctl_r) :
        (ar_idx == `IDX_RC_TRIM) ? {1'b0, trim_r} :
        (ar_idx == `IDX_CKOUT_EN) ? {7'h00, ckout_en_r} :
        (ar_idx == `IDX_STATUS) ? stat_v :
        (ar_idx == `IDX_PIN_FLAGS) ? pin_flag_r : 8'h00;
    wire rd_known = (ar_idx == `IDX_EXT_WAKE) || (ar_idx == `IDX_PWR_CTL)
        || (ar_idx == `IDX_P1_WAKE) || (ar_idx == `IDX_CLK_CTL)
        || (ar_idx == `IDX_RC_TRIM) || (ar_idx == `IDX_CKOUT_EN)
        || (ar_idx == `IDX_STATUS) || (ar_idx == `IDX_PIN_FLAGS);

    // ==========================================
    // AXI4-Lite handshakes, one write and one read at a time
    assign s_axi_awready = ~aw_have_r;
    assign s_axi_wready = ~w_have_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    // Write side: halves may come in either order
    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_idx_r <= 10'h000;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_have_r) begin
                aw_have_r <= 1'b1;
                aw_idx_r <= s_axi_awaddr[11:2];
            end else if (wr_fire) aw_have_r <= 1'b0;
            if (s_axi_wvalid && !w_have_r) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
            end else if (wr_fire) w_have_r <= 1'b0;
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) bvalid_r <= 1'b0;
        end
    end
    // Read side: answer one cycle after the address is taken
    always_ff @(posedge mclk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_v};
            rresp_r <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) rvalid_r <= 1'b0;
    end

    // ==========================================
    // Checks
    logic [4:0] psc_stable_r; // Cycles the divider code stood still
    always_ff @(posedge mclk) begin
        if (rst || (ctl_nxt.sysclk_divider != ctl_r.sysclk_divider)) psc_stable_r <= 5'h00;
        else if (psc_stable_r != 5'h1F) psc_stable_r <= psc_stable_r + 5'h01;
    end
    sequence s_down_req;
        down_go ##1 !rst;
    endsequence
    sequence s_asleep_wake;
        (st_r == PW_STOP) && pin_wake;
    endsequence
    a_slow_pick_lock: assert property (@(posedge mclk) disable iff (rst)
        !ctl_r.sysclk_fast_pick |=> $stable(ctl_r.slow_source_pick)) else $error("slow pick moved");
    a_fast_pick_lock: assert property (@(posedge mclk) disable iff (rst)
        ctl_r.sysclk_fast_pick |=> $stable(ctl_r.fast_source_pick)) else $error("fast pick moved");
    a_sel_lock: assert property (@(posedge mclk) disable iff (rst)
        ctl_r.fast_osc_halt |=> $stable(ctl_r.sysclk_fast_pick)) else $error("source moved");
    a_halt_bit_lock: assert property (@(posedge mclk) disable iff (rst)
        ctl_r.sysclk_fast_pick |=> $stable(ctl_r.fast_osc_halt)) else $error("halt bit moved");
    a_no_bad_combo: assert property (@(posedge mclk) disable iff (rst)
        !(ctl_r.fast_osc_halt && ctl_r.sysclk_fast_pick)) else $error("halt with fast pick");
    a_psc_applied: assert property (@(posedge mclk) disable iff (rst)
        psc_stable_r >= 5'd16 |-> psc_act_r == ctl_r.sysclk_divider) else $error("divider late");
    a_down_refused: assert property (@(posedge mclk) disable iff (rst)
        (wr_pwr && w_data_r[`PWR_DOWN_BIT] && down_block && st_r == PW_RUN)
        |=> st_r != PW_HALT && st_r != PW_STOP) else $error("entered while pin low");
    a_down_mode: assert property (@(posedge mclk) disable iff (rst)
        s_down_req |-> down_r
        && st_r == ($past(ctl_r.slow_osc_halt_on_powerdown) ? PW_STOP : PW_HALT))
        else $error("wrong sleep mode");
    a_stop_wake: assert property (@(posedge mclk) disable iff (rst)
        s_asleep_wake |=> st_r == PW_RUN && !down_r) else $error("stop not left");
    a_stop_holds: assert property (@(posedge mclk) disable iff (rst)
        (st_r == PW_STOP && !pin_wake) |=> st_r == PW_STOP) else $error("stop left early");
    a_idle_gate: assert property (@(posedge mclk) disable iff (rst)
        (st_r == PW_IDLE && ctl_r.periph_gate_in_idle) |-> !periph_clk_en && !cpu_clk_en)
        else $error("idle gate leak");
    a_ckout_fast: assert property (@(posedge mclk) disable iff (rst)
        (!$past(rst) && $past(sys_tick))
        |-> half_rate_clock_out != $past(half_rate_clock_out)) else $error("clock out stuck");
endmodule

// ===== tb/system_clock_and_power_modes_tb.sv
// Self-checking bench for the clock and power block, driven over AXI4-Lite.
// Assumes the package and the constants header are compiled ahead of it.
`timescale 1ns/1ps
`include "clkpwr_consts.svh"
module system_clock_and_power_modes_tb import clkpwr_pkg::*;;
// ==========================================================================
// Signals
logic mclk, rst;
logic [11:0] awaddr, araddr;
logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
logic [31:0] wdata, rdata, rv;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, rsp;
logic [9:0] ext_pin; // Idle high, low requests wake
logic [7:0] p1_pin;
logic [1:0] ex01;
logic shared_en, irq_pend, t3_irq, t3_wake, t3_en, wdt_en;
logic sys_tick, hco, hco_oe, fast_run, slow_run, xtal, hgain, is_fast;
logic [6:0] trim;
logic cpu_en, per_en, t3_clk, wdt_clk, hco_d;
int bad_count, n_checks, ticks, toggles, k;
int dv[4] = '{16, 4, 2, 1}; // Divide ratio per divider code
logic [7:0] wv[10] = '{8'h63, 8'h67, 8'h27, 8'hE7, 8'hEF, 8'hE3, 8'hEF, 8'hEF, 8'hE3, 8'hA3};
logic [7:0] ev[10] = '{8'h63, 8'h67, 8'h67, 8'hE7, 8'hE7, 8'hE3, 8'hEB, 8'hEB, 8'hE3, 8'hA3};
localparam logic [11:0] A_EXT = {`IDX_EXT_WAKE, 2'b00};
localparam logic [11:0] A_PWR = {`IDX_PWR_CTL, 2'b00};
localparam logic [11:0] A_P1 = {`IDX_P1_WAKE, 2'b00};
localparam logic [11:0] A_CLK = {`IDX_CLK_CTL, 2'b00};
localparam logic [11:0] A_TRIM = {`IDX_RC_TRIM, 2'b00};
localparam logic [11:0] A_OE = {`IDX_CKOUT_EN, 2'b00};
localparam logic [11:0] A_ST = {`IDX_STATUS, 2'b00};
localparam logic [11:0] A_FLG = {`IDX_PIN_FLAGS, 2'b00};
// ==========================================================================
// Design under test
system_clock_and_power_modes dut_u (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_irq_pin(ext_pin), .port1_pin(p1_pin), .ex01_wake_en(ex01),
    .shared_pin_lowvolt_irq_enable(shared_en), .irq_pending(irq_pend), .timer3_irq(t3_irq),
    .timer3_wake_en(t3_wake), .timer3_en(t3_en), .wdt_en(wdt_en), .sys_tick(sys_tick),
    .half_rate_clock_out(hco), .half_rate_clock_out_oe(hco_oe), .fast_osc_run(fast_run),
    .slow_osc_run(slow_run), .xtal_pins_osc(xtal), .osc_high_gain(hgain),
    .sysclk_is_fast(is_fast), .fast_rc_trim_value(trim), .cpu_clk_en(cpu_en),
    .periph_clk_en(per_en), .timer3_clk_en(t3_clk), .wdt_clk_en(wdt_clk));
// ==========================================================================
// Clock, tick and toggle counters
initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
end
// Counted on the edge, so a one-cycle tick is never missed
always @(posedge mclk) begin
    if (sys_tick === 1'b1) ticks++;
    if (hco !== hco_d) toggles++;
    hco_d = hco;
end
// ==========================================================================
// Bus and check tasks
task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
        bad_count++;
        $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
endtask
// Address and data offered together; each released once taken
task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
        @(posedge mclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid === 1'b1) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (i == 40) bad_count++;
endtask
task automatic rd(input logic [11:0] a);
    int i;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
        @(posedge mclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid === 1'b1) break;
    end
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (i == 40) bad_count++;
endtask
task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, {24'h000000, e}, rv);
endtask
// Waits n edges, then settles at the falling edge
task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
endtask
task automatic wrap_up();
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
// ==========================================================================
// Watchdog: twice the crystal wait, well above the crystal wait plus the tests
initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    wrap_up();
end
// ==========================================================================
// Main sequence
initial begin
    {rst, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = {1'b1, 29'h0};
    {wdata, wstrb, ext_pin, p1_pin, ex01} = {32'h0, 4'hF, 10'h3FF, 8'h00, 2'h0};
    {shared_en, irq_pend, t3_irq, t3_wake, t3_en, wdt_en, hco_d} = 7'b0001100;
    {bad_count, n_checks, ticks, toggles} = 128'h0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    cyc(3);
    chk("is_fast", 0, is_fast);
    chk("slow_run", 1, slow_run);
    rc("clk_ctl", A_CLK, `RST_CLK_CTL);
    rc("pwr_ctl", A_PWR, 8'h00);
    rc("trim", A_TRIM, 8'h40);
    rc("ext_wake", A_EXT, 8'h00);
    rc("p1_wake", A_P1, 8'h00);
    rd(12'h004);
    chk("rd_resp", `RESP_SLVERR, rsp);
    wr(12'h008, 8'h55);
    chk("wr_resp", `RESP_SLVERR, rsp);
    wr(A_CLK, 8'hA2);
    rc("clk_ctl", A_CLK, 8'h22);
    wr(A_OE, 8'h01);
    cyc(0);
    chk("ck_oe", 1, hco_oe);
    for (k = 0; k < 4; k++) begin
        wr(A_CLK, 8'h20 | k[7:0]);
        cyc(16);
        {ticks, toggles} = 64'h0;
        cyc(64);
        chk("ticks", 64 / dv[k], ticks);
        chk("toggles", 64 / dv[k], toggles);
    end
    // Source switching table, single-bit steps plus one joint halt and pick step, with refused steps
    for (k = 0; k < 10; k++) begin
        if (k == 1) cyc(`XTAL_WAIT_CYC);
        wr(A_CLK, wv[k]);
        rc("clk_ctl", A_CLK, ev[k]);
        chk("is_fast", ev[k][2], is_fast);
        chk("fast_run", !ev[k][3], fast_run);
        chk("gain", ev[k][6], hgain);
        if (!ev[k][7]) chk("xtal", ev[k][6], xtal);
    end
    wr(A_TRIM, 8'h7F);
    cyc(0);
    chk("trim_out", 8'h7F, trim);
    // Idle with and without peripheral gating
    for (k = 0; k < 2; k++) begin
        wr(A_CLK, k ? 8'hB3 : 8'hA3);
        wr(A_PWR, 8'h01);
        rc("status", A_ST, 8'h09);
        chk("cpu_en", 0, cpu_en);
        chk("per_en", k == 0, per_en);
        @(posedge mclk);
        irq_pend <= 1'b1;
        cyc(3);
        rc("status", A_ST, 8'h04);
        rc("pwr_ctl", A_PWR, 8'h00);
        @(posedge mclk);
        irq_pend <= 1'b0;
    end
    // Halt, woken by the timer
    wr(A_CLK, 8'h83);
    wr(A_PWR, 8'h02);
    rc("status", A_ST, 8'h12);
    chk("t3_clk", 1, t3_clk);
    chk("wdt_clk", 0, wdt_clk);
    chk("fast_run", 0, fast_run);
    chk("cpu_en", 0, cpu_en);
    @(posedge mclk);
    t3_irq <= 1'b1;
    cyc(3);
    rc("status", A_ST, 8'h04);
    // Stop: timer ignored, pin needs the shared enable
    wr(A_CLK, 8'hA3);
    wr(A_EXT, 8'h01);
    wr(A_PWR, 8'h02);
    cyc(3);
    rc("status", A_ST, 8'h22);
    chk("slow_run", 0, slow_run);
    chk("t3_clk", 0, t3_clk);
    @(posedge mclk);
    t3_irq <= 1'b0;
    ext_pin[2] <= 1'b0;
    cyc(5);
    rc("status", A_ST, 8'h22);
    @(posedge mclk);
    ext_pin[2] <= 1'b1;
    shared_en <= 1'b1;
    cyc(5);
    @(posedge mclk);
    ext_pin[2] <= 1'b0;
    cyc(5);
    rc("status", A_ST, 8'h04);
    rc("flags", A_FLG, 8'h01);
    wr(A_FLG, 8'h01);
    rc("flags", A_FLG, 8'h00);
    wr(A_PWR, 8'h02);
    rc("status", A_ST, 8'h04);
    @(posedge mclk);
    ext_pin[2] <= 1'b1;
    // Port 1 change wake
    wr(A_P1, 8'h10);
    wr(A_PWR, 8'h02);
    rc("status", A_ST, 8'h22);
    @(posedge mclk);
    p1_pin[4] <= 1'b1;
    cyc(5);
    rc("status", A_ST, 8'h04);
    // Low pin 0 with its enable also refuses power down
    @(posedge mclk);
    ex01 <= 2'h1;
    ext_pin[0] <= 1'b0;
    wr(A_PWR, 8'h02);
    rc("status", A_ST, 8'h04);
    @(posedge mclk);
    ext_pin[0] <= 1'b1;
    // Flag set with the pin disabled
    wr(A_EXT, 8'h00);
    @(posedge mclk);
    ext_pin[3] <= 1'b0;
    cyc(5);
    rc("flags", A_FLG, 8'h02);
    wrap_up();
end
endmodule
